//--- perp_user_end.sv
// Purpose: User logic end; turns high-level error requests into one-cycle reports.
// Assumes: Requests are single-cycle pulses; header valid with the request.
// Notes: UR and abort requests wait while the device fifo is not ready.
`timescale 1ns/10ps
module perp_user_end
  import perp_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  perp_if.user port,
  input wire logic req_unsupported_i,
  input wire logic req_aborted_i,
  input wire logic req_timeout_i,
  input wire logic req_unexpected_i,
  input wire logic req_crc_i,
  input wire logic req_int_corrected_i,
  input wire logic req_int_uncorrectable_i,
  input wire logic req_malformed_i,
  input wire logic req_mc_blocked_i,
  input wire logic req_poisoned_i,
  input wire logic qual_posted_i,
  input wire logic qual_locked_i,
  input wire logic qual_no_recovery_i,
  input wire logic [6:0] pkt_lower_addr_i,
  input wire logic [11:0] pkt_byte_count_i,
  input wire logic [2:0] pkt_tc_i,
  input wire logic [1:0] pkt_attr_i,
  input wire logic [15:0] pkt_requester_id_i,
  input wire logic [7:0] pkt_tag_i,
  output logic busy_o
);
  logic [PERP_HDR_W-1:0] hdr;
  logic [9:0] rep;
  logic posted;
  logic locked;
  logic no_rec;
  logic ur_hold;
  logic ca_hold;
  logic held_locked;
  logic held_posted;
  wire dev_ready = !port.err_hdr_fifo_ready_n;
  // Report on the wire not yet in the fifo count, so ready is stale
  wire in_flight = rep[9] || rep[8];
  wire [PERP_HDR_W-1:0] next_hdr = {pkt_lower_addr_i, pkt_byte_count_i, pkt_tc_i,
                                    pkt_attr_i, pkt_requester_id_i, pkt_tag_i};
  wire ur_go = (req_unsupported_i || ur_hold) && dev_ready && !in_flight;
  wire ca_go = (req_aborted_i || ca_hold) && dev_ready && !in_flight && !ur_go;
  // A waiting report carries the qualifiers of its own request
  wire from_hold = (ur_go && ur_hold) || (ca_go && ca_hold);

  // Completion-requiring reports held until device fifo ready
  assign busy_o = ur_hold || ca_hold;

  // Registered one-cycle reports and qualifiers
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      rep <= '0;
      hdr <= '0;
      posted <= 1'b0;
      locked <= 1'b0;
      no_rec <= 1'b0;
      ur_hold <= 1'b0;
      ca_hold <= 1'b0;
      held_locked <= 1'b0;
      held_posted <= 1'b0;
    end else begin
      rep <= {ur_go, ca_go, req_timeout_i, req_unexpected_i, req_crc_i,
              req_int_corrected_i, req_int_uncorrectable_i, req_malformed_i,
              req_mc_blocked_i, req_poisoned_i};
      hdr <= (req_unsupported_i || req_aborted_i) ? next_hdr : hdr;
      held_locked <= (req_unsupported_i || req_aborted_i) ? qual_locked_i : held_locked;
      held_posted <= (req_unsupported_i || req_aborted_i) ? qual_posted_i : held_posted;
      posted <= from_hold ? held_posted : qual_posted_i;
      locked <= from_hold ? held_locked : qual_locked_i;
      no_rec <= qual_no_recovery_i;
      ur_hold <= (req_unsupported_i || ur_hold) && !ur_go;
      ca_hold <= (req_aborted_i || ca_hold) && !ca_go;
    end
  end

  // Active-low drive of the port reports; header driven unchanged
  assign port.err_unsupported_req_n = !rep[9];
  assign port.err_completion_aborted_n = !rep[8];
  assign port.err_completion_timeout_n = !rep[7];
  assign port.err_unexpected_completion_n = !rep[6];
  assign port.err_end_to_end_crc_n = !rep[5];
  assign port.err_internal_corrected_n = !rep[4];
  assign port.err_internal_uncorrectable_n = !rep[3];
  assign port.err_malformed_n = !rep[2];
  assign port.err_multicast_blocked_n = !rep[1];
  assign port.err_poisoned_packet_n = !rep[0];
  assign port.err_posted_qualifier_n = !posted;
  assign port.err_locked_qualifier_n = !locked;
  assign port.err_no_recovery_n = !no_rec;
  assign port.err_completion_header = hdr;
endmodule

//--- perp_pkg.sv
// Purpose: Shared constants and types for the error report port.
// Assumes: One system clock; all signals but the header active low at the port.
// Notes: Header layout and fifo depth live here.
package perp_pkg;
  localparam int PERP_HDR_W = 48;
  localparam int PERP_LA_HI = 47;
  localparam int PERP_LA_LO = 41;
  localparam int PERP_BC_HI = 40;
  localparam int PERP_BC_LO = 29;
  localparam int PERP_TC_HI = 28;
  localparam int PERP_TC_LO = 26;
  localparam int PERP_AT_HI = 25;
  localparam int PERP_AT_LO = 24;
  localparam int PERP_RID_HI = 23;
  localparam int PERP_RID_LO = 8;
  localparam int PERP_TAG_HI = 7;
  localparam int PERP_TAG_LO = 0;
  localparam int PERP_FIFO_DEPTH = 4;
  localparam int PERP_PTR_W = 2;
  localparam int PERP_CNT_W = 3;
  localparam int PERP_STAT_W = 16;
  localparam logic [2:0] PERP_CPL_UR = 3'h1;
  localparam logic [2:0] PERP_CPL_CA = 3'h4;
  localparam logic [PERP_STAT_W-1:0] PERP_STAT_RST = 16'h0000;
  // Completion request record given to the completion generator
  typedef struct packed {
    logic locked;
    logic [2:0] status;
    logic [PERP_HDR_W-1:0] hdr;
  } perp_cpl_t;
  localparam int PERP_CPL_W = PERP_HDR_W + 4;
endpackage

//--- perp_if.sv
// Purpose: Carrier joining the user logic end and the device end.
// Assumes: All report signals active low, one clock.
// Notes: One modport per party.
`timescale 1ns/10ps
interface perp_if;
  import perp_pkg::*;
  logic err_hdr_fifo_ready_n;
  logic [PERP_HDR_W-1:0] err_completion_header;
  logic err_unsupported_req_n;
  logic err_completion_aborted_n;
  logic err_completion_timeout_n;
  logic err_unexpected_completion_n;
  logic err_end_to_end_crc_n;
  logic err_internal_corrected_n;
  logic err_internal_uncorrectable_n;
  logic err_locked_qualifier_n;
  logic err_malformed_n;
  logic err_multicast_blocked_n;
  logic err_no_recovery_n;
  logic err_poisoned_packet_n;
  logic err_posted_qualifier_n;
  modport device (
    output err_hdr_fifo_ready_n,
    input err_completion_header, err_unsupported_req_n, err_completion_aborted_n,
    input err_completion_timeout_n, err_unexpected_completion_n, err_end_to_end_crc_n,
    input err_internal_corrected_n, err_internal_uncorrectable_n, err_locked_qualifier_n,
    input err_malformed_n, err_multicast_blocked_n, err_no_recovery_n,
    input err_poisoned_packet_n, err_posted_qualifier_n
  );
  modport user (
    input err_hdr_fifo_ready_n,
    output err_completion_header, err_unsupported_req_n, err_completion_aborted_n,
    output err_completion_timeout_n, err_unexpected_completion_n, err_end_to_end_crc_n,
    output err_internal_corrected_n, err_internal_uncorrectable_n, err_locked_qualifier_n,
    output err_malformed_n, err_multicast_blocked_n, err_no_recovery_n,
    output err_poisoned_packet_n, err_posted_qualifier_n
  );
endinterface

//--- perp_hdr_fifo.sv
// Purpose: Small header fifo holding pending error completions.
// Assumes: Single clock, writer checks ready before pushing.
// Notes: Depth fixed by the package.
`timescale 1ns/10ps
module perp_hdr_fifo
  import perp_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic push_i,
  input wire logic [PERP_CPL_W-1:0] push_data_i,
  output logic can_push_o,
  output logic pop_valid_o,
  input wire logic pop_ready_i,
  output logic [PERP_CPL_W-1:0] pop_data_o
);
  logic [PERP_CPL_W-1:0] mem [PERP_FIFO_DEPTH];
  logic [PERP_PTR_W-1:0] wr_ptr;
  logic [PERP_PTR_W-1:0] rd_ptr;
  logic [PERP_CNT_W-1:0] count;
  wire do_push = push_i && can_push_o;
  wire do_pop = pop_valid_o && pop_ready_i;

  // Occupancy flags
  assign can_push_o = count != PERP_CNT_W'(PERP_FIFO_DEPTH);
  assign pop_valid_o = count != '0;
  assign pop_data_o = mem[rd_ptr];

  // Storage array
  always_ff @(posedge clk_sys_i) begin
    if (do_push) begin
      mem[wr_ptr] <= push_data_i;
    end
  end

  // Pointers and count
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= wr_ptr + PERP_PTR_W'(do_push);
      rd_ptr <= rd_ptr + PERP_PTR_W'(do_pop);
      count <= count + PERP_CNT_W'(do_push) - PERP_CNT_W'(do_pop);
    end
  end
endmodule

//--- perp_device_end.sv
// Purpose: Device end of the error report port; latches reports, queues completions.
// Assumes: Reports are one-cycle active-low pulses on clk_sys_i.
// Notes: Counters are sticky summaries; completion drained by cpl_ready_i.
`timescale 1ns/10ps

// What this block does
// - Ready low while header fifo has room
// - Ignore UR and abort while not ready
// - User pulses completion timeout report
// - User pulses unexpected completion report
// - User pulses end-to-end CRC error
// - User pulses corrected internal error
// - User pulses uncorrectable internal error
// - Locked qualifier turns Cpl into CplLk
// - User pulses multicast blocked report
// - No-recovery marks poison or timeout fatal
// - Poison report used only with bypass attribute
// - Posted qualifier suppresses any completion
// - Header packs address, count, class, attr, ID, tag
// - Header fields come from offending packet
// - Queued header drives the error completion
// - User pulses unsupported request report
// - User pulses completion aborted report
module perp_device_end
  import perp_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  perp_if.device port,
  input wire logic poison_response_bypass_attr_i,
  output logic cpl_valid_o,
  input wire logic cpl_ready_i,
  output logic cpl_locked_o,
  output logic [2:0] cpl_status_o,
  output logic [PERP_HDR_W-1:0] cpl_header_o,
  output logic [PERP_STAT_W-1:0] unsupported_count_o,
  output logic [PERP_STAT_W-1:0] aborted_count_o,
  output logic [PERP_STAT_W-1:0] timeout_count_o,
  output logic [PERP_STAT_W-1:0] poisoned_count_o,
  output logic fatal_seen_o,
  output logic correctable_seen_o,
  output logic uncorrectable_seen_o
);
  logic fifo_can_push;
  logic [PERP_CPL_W-1:0] fifo_out;
  perp_cpl_t push_rec;
  perp_cpl_t pop_rec;

  function automatic logic [PERP_STAT_W-1:0] sat_inc(input logic [PERP_STAT_W-1:0] v,
                                                  input logic hit);
    sat_inc = (hit && v != '1) ? v + PERP_STAT_W'(1) : v;
  endfunction

  // Decoded report strobes, active high
  wire posted = !port.err_posted_qualifier_n;
  wire no_recovery = !port.err_no_recovery_n;
  wire ur_taken = !port.err_unsupported_req_n && fifo_can_push;
  wire ca_taken = !port.err_completion_aborted_n && fifo_can_push;
  wire poison_hit = !port.err_poisoned_packet_n && poison_response_bypass_attr_i;
  wire timeout_hit = !port.err_completion_timeout_n;
  wire fatal_hit = no_recovery && (poison_hit || timeout_hit);
  wire need_cpl = (ur_taken || ca_taken) && !posted;
  wire correctable_hit = !port.err_internal_corrected_n || !port.err_end_to_end_crc_n
                         || (!port.err_unexpected_completion_n && posted);
  wire uncorrectable_hit = !port.err_internal_uncorrectable_n || !port.err_malformed_n
                           || !port.err_multicast_blocked_n
                           || (!port.err_unexpected_completion_n && !posted);

  // Completion record from captured header
  always_comb begin
    push_rec.locked = !port.err_locked_qualifier_n;
    push_rec.status = ur_taken ? PERP_CPL_UR : PERP_CPL_CA;
    push_rec.hdr = port.err_completion_header;
  end

  // Ready flag toward user logic
  assign port.err_hdr_fifo_ready_n = !fifo_can_push;

  perp_hdr_fifo i_perp_hdr_fifo (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .push_i(need_cpl),
    .push_data_i(push_rec),
    .can_push_o(fifo_can_push),
    .pop_valid_o(cpl_valid_o),
    .pop_ready_i(cpl_ready_i),
    .pop_data_o(fifo_out)
  );

  // Completion generator view of the head entry
  assign pop_rec = perp_cpl_t'(fifo_out);
  assign cpl_locked_o = pop_rec.locked;
  assign cpl_status_o = pop_rec.status;
  assign cpl_header_o = pop_rec.hdr;

  // Event counters and sticky summaries
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      unsupported_count_o <= PERP_STAT_RST;
      aborted_count_o <= PERP_STAT_RST;
      timeout_count_o <= PERP_STAT_RST;
      poisoned_count_o <= PERP_STAT_RST;
      fatal_seen_o <= 1'b0;
      correctable_seen_o <= 1'b0;
      uncorrectable_seen_o <= 1'b0;
    end else begin
      unsupported_count_o <= sat_inc(unsupported_count_o, ur_taken);
      aborted_count_o <= sat_inc(aborted_count_o, ca_taken);
      timeout_count_o <= sat_inc(timeout_count_o, timeout_hit);
      poisoned_count_o <= sat_inc(poisoned_count_o, poison_hit);
      fatal_seen_o <= fatal_seen_o || fatal_hit;
      correctable_seen_o <= correctable_seen_o || correctable_hit;
      uncorrectable_seen_o <= uncorrectable_seen_o || uncorrectable_hit;
    end
  end
endmodule

//--- perp_assertions.sv
// Purpose: Watches the report port wires between both ends
// Assumes: One clock, synchronous active low reset
// Notes: Header bus not watched here
`timescale 1ns/10ps
module perp_assertions (
  input logic clk_sys_i,
  input logic rst_b_i,
  input logic err_hdr_fifo_ready_n,
  input logic err_unsupported_req_n,
  input logic err_completion_aborted_n,
  input logic err_completion_timeout_n,
  input logic err_unexpected_completion_n,
  input logic err_end_to_end_crc_n,
  input logic err_internal_corrected_n,
  input logic err_internal_uncorrectable_n,
  input logic err_locked_qualifier_n,
  input logic err_malformed_n,
  input logic err_multicast_blocked_n,
  input logic err_no_recovery_n,
  input logic err_poisoned_packet_n,
  input logic err_posted_qualifier_n
);
  // Any report present this cycle
  wire logic any_rep = !(err_unsupported_req_n && err_completion_aborted_n
    && err_completion_timeout_n && err_unexpected_completion_n && err_end_to_end_crc_n
    && err_internal_corrected_n && err_internal_uncorrectable_n && err_malformed_n
    && err_multicast_blocked_n && err_poisoned_packet_n);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  a_ready_at_start: assert property ($rose(rst_b_i) |-> !err_hdr_fifo_ready_n)
    else $error("fifo not ready after reset");
  a_ur_needs_ready: assert property (!err_unsupported_req_n |-> !err_hdr_fifo_ready_n)
    else $error("UR sent while fifo full");
  a_ca_needs_ready: assert property (!err_completion_aborted_n |-> !err_hdr_fifo_ready_n)
    else $error("abort sent while fifo full");
  a_timeout_one_cycle: assert property (!err_completion_timeout_n |=> err_completion_timeout_n)
    else $error("timeout pulse too long");
  a_poison_one_cycle: assert property (!err_poisoned_packet_n |=> err_poisoned_packet_n)
    else $error("poison pulse too long");
  a_malformed_one_cycle: assert property (!err_malformed_n |=> err_malformed_n)
    else $error("malformed pulse too long");
  a_locked_qualifies: assert property (!err_locked_qualifier_n |->
    !(err_unsupported_req_n && err_completion_aborted_n))
    else $error("locked without UR or abort");
  a_norec_qualifies: assert property (!err_no_recovery_n |->
    !(err_poisoned_packet_n && err_completion_timeout_n))
    else $error("no recovery without its report");
  a_posted_qualifies: assert property (!err_posted_qualifier_n |-> any_rep)
    else $error("posted without a report");
  // Main scenarios
  cover property (!err_unsupported_req_n && !err_locked_qualifier_n);
  cover property (err_hdr_fifo_ready_n);
  cover property (!err_completion_timeout_n && !err_no_recovery_n);
endmodule

//--- pcie_error_report_port_tb.sv
// Purpose: Self-checking bench joining user end and device end
// Assumes: Reports spaced apart, inputs set on falling edges
// Notes: Completions compared against a queue of notes
`timescale 1ns/10ps
module pcie_error_report_port_tb;
  import perp_pkg::*;
  logic clk_sys_i = 0, rst_b_i = 0, attr = 0, stall = 1, cpl_rdy = 0;
  logic [9:0] rq = 0;
  logic [2:0] ql = 0;
  logic [47:0] h = 0;
  logic cv, lk, busy, fat, cor, unc;
  logic [2:0] st;
  logic [47:0] hd;
  logic [15:0] c_ur, c_ca, c_to, c_po;
  perp_cpl_t notes[$];
  int seed = 6649, miscompares = 0, cmp_count = 0;
  perp_if link ();
  // Clock, 8 ns period
  always #4 clk_sys_i = ~clk_sys_i;
  perp_user_end i_perp_user_end (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .port(link.user),
    .req_unsupported_i(rq[0]), .req_aborted_i(rq[1]), .req_timeout_i(rq[2]),
    .req_unexpected_i(rq[3]), .req_crc_i(rq[4]), .req_int_corrected_i(rq[5]),
    .req_int_uncorrectable_i(rq[6]), .req_malformed_i(rq[7]), .req_mc_blocked_i(rq[8]),
    .req_poisoned_i(rq[9]), .qual_posted_i(ql[0]), .qual_locked_i(ql[1]),
    .qual_no_recovery_i(ql[2]), .pkt_lower_addr_i(h[47:41]), .pkt_byte_count_i(h[40:29]),
    .pkt_tc_i(h[28:26]), .pkt_attr_i(h[25:24]), .pkt_requester_id_i(h[23:8]),
    .pkt_tag_i(h[7:0]), .busy_o(busy));
  perp_device_end i_perp_device_end (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .port(link.device), .poison_response_bypass_attr_i(attr), .cpl_valid_o(cv),
    .cpl_ready_i(cpl_rdy), .cpl_locked_o(lk), .cpl_status_o(st), .cpl_header_o(hd),
    .unsupported_count_o(c_ur), .aborted_count_o(c_ca), .timeout_count_o(c_to),
    .poisoned_count_o(c_po), .fatal_seen_o(fat), .correctable_seen_o(cor),
    .uncorrectable_seen_o(unc));
  perp_assertions i_chk (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .err_hdr_fifo_ready_n(link.err_hdr_fifo_ready_n),
    .err_unsupported_req_n(link.err_unsupported_req_n),
    .err_completion_aborted_n(link.err_completion_aborted_n),
    .err_completion_timeout_n(link.err_completion_timeout_n),
    .err_unexpected_completion_n(link.err_unexpected_completion_n),
    .err_end_to_end_crc_n(link.err_end_to_end_crc_n),
    .err_internal_corrected_n(link.err_internal_corrected_n),
    .err_internal_uncorrectable_n(link.err_internal_uncorrectable_n),
    .err_locked_qualifier_n(link.err_locked_qualifier_n),
    .err_malformed_n(link.err_malformed_n), .err_multicast_blocked_n(link.err_multicast_blocked_n),
    .err_no_recovery_n(link.err_no_recovery_n), .err_poisoned_packet_n(link.err_poisoned_packet_n),
    .err_posted_qualifier_n(link.err_posted_qualifier_n));
  // Random take-up of completions while not stalled
  always @(negedge clk_sys_i) cpl_rdy <= !stall && ($random(seed) & 1);
  // Compare each taken completion with the oldest note
  always @(posedge clk_sys_i) begin
    perp_cpl_t e;
    if (rst_b_i && cv === 1'b1 && cpl_rdy === 1'b1) begin
      e = notes.size() ? notes.pop_front() : '1;
      cmp_count++;
      if ({lk, st, hd} !== e) begin
        miscompares++;
        $display("CHECK FAILED cpl expected %h seen %h", e, {lk, st, hd});
      end
    end
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // One request pulse with fresh header, noting any owed completion
  task automatic send(input int r, input logic [2:0] q);
    @(negedge clk_sys_i);
    h = 48'({$random(seed), $random(seed)});
    rq = 10'h1 << r;
    ql = q;
    if (r < 2 && !q[0]) notes.push_back({q[1], r ? PERP_CPL_CA : PERP_CPL_UR, h});
    @(negedge clk_sys_i);
    rq = 0;
    ql = 0;
    repeat (3) @(negedge clk_sys_i);
  endtask
  // Let the far side take all pending completions
  task automatic drain();
    stall = 0;
    for (int i = 0; i < 300 && (notes.size() || cv !== 1'b0); i++) @(negedge clk_sys_i);
    stall = 1;
  endtask
  task automatic results();
    $display("compares %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    #100000;
    miscompares++;
    results();
  end
  // Main sequence
  initial begin
    repeat (16) @(negedge clk_sys_i);
    rst_b_i = 1;
    chk("reset counts", 0, c_ur | c_ca | c_to | c_po);
    chk("reset flags", 0, {fat, cor, unc, cv});
    send(5, 3'h0);
    chk("cor unc", 2, {cor, unc});
    send(6, 3'h0);
    chk("unc", 1, unc);
    send(0, 3'h2);
    send(0, 3'h0);
    send(1, 3'h2);
    send(0, 3'h1);
    drain();
    chk("ur count", 3, c_ur);
    chk("ca count", 1, c_ca);
    repeat (4) send(0, 3'h0);
    chk("ready_n full", 1, link.err_hdr_fifo_ready_n);
    send(0, 3'h0);
    chk("busy", 1, busy);
    chk("ur held", 7, c_ur);
    drain();
    chk("ur count", 8, c_ur);
    chk("ready_n room", 0, link.err_hdr_fifo_ready_n);
    send(2, 3'h0);
    chk("fatal", 0, fat);
    send(2, 3'h4);
    chk("to count", 2, c_to);
    chk("fatal", 1, fat);
    send(9, 3'h4);
    chk("poison off", 0, c_po);
    attr = 1;
    send(9, 3'h0);
    chk("poison on", 1, c_po);
    // Mid-run reset clears sticky summaries
    rst_b_i = 0;
    repeat (2) @(negedge clk_sys_i);
    rst_b_i = 1;
    chk("reset again", 0, {fat, cor, unc, cv, c_po[0]});
    send(3, 3'h1);
    chk("unexp posted", 2, {cor, unc});
    send(7, 3'h0);
    chk("malformed", 3, {cor, unc});
    for (int i = 3; i < 9; i++) send(i, 3'h0);
    chk("notes left", 0, 16'(notes.size()));
    results();
  end
endmodule
